// ---- logic/sbv_unit.sv ----
/*
  SIMD bit flip/set, bitwise select and vector branch execution unit.
  Assumes the pipeline issues one op per valid pulse with operands read from
  the register file, and never places a branch in a vector branch delay slot.
*/
`timescale 1ns/1ps
// Contract
// - Variable flip inverts one bit per element, index from select lane.
// - Immediate flip inverts one bit per element, index from immediate.
// - Variable set forces one bit per element to one.
// - Element format picks byte, half, word or double lanes.
// - Flip and set never raise value-dependent exceptions.
// - Per-format branch taken only when every element is nonzero.
// - Any-bit branch taken when any vector bit is one.
// - One delay slot; signed 16-bit word offset from delay slot.
// - Byte offset is sign-extended word offset times four, added in the branch cycle.
// - Vector select: destination bit picks first source or second source.
// - Immediate select: destination bit picks source or byte immediate.
// - Select ops ignore element format.
// - Reserved exception if absent, disabled exception if unit off.
module sbv_unit
  import sbv_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             op_valid,
  input  wire logic [2:0]       op_code,
  input  wire logic [1:0]       element_format,
  input  wire logic [VEC_W-1:0] first_source_vector,
  input  wire logic [VEC_W-1:0] select_vector,
  input  wire logic [VEC_W-1:0] dest_vector,
  input  wire logic [IMM_W-1:0] byte_immediate,
  input  wire logic [OFF_W-1:0] branch_word_offset,
  input  wire logic [GP_W-1:0]  delay_slot_pc,
  input  wire logic             unit_present,
  input  wire logic             unit_enabled,
  output logic      [VEC_W-1:0] result_ff,
  output logic                  result_valid_ff,
  output logic                  branch_taken_ff,
  output logic                  pc_load_ff,
  output logic      [GP_W-1:0]  pc_target_ff,
  output logic                  exc_reserved_ff,
  output logic                  exc_disabled_ff
);
  logic [VEC_W-1:0] flip_set_res;
  logic [VEC_W-1:0] nxt_result;
  logic             br_cond;
  logic [GP_W-1:0]  br_byte_off;
  logic [GP_W-1:0]  br_target_ff;
  sbv_state_t       state_ff;
  sbv_state_t       nxt_state;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  wire is_flip_var = op_code == SBV_OP_FLIP_VAR;
  wire is_flip_imm = op_code == SBV_OP_FLIP_IMM;
  wire is_set_var  = op_code == SBV_OP_SET_VAR;
  wire is_sel_vec  = op_code == SBV_OP_SEL_VEC;
  wire is_sel_imm  = op_code == SBV_OP_SEL_IMM;
  wire is_br_all   = op_code == SBV_OP_BR_ALL;
  wire is_br_any   = op_code == SBV_OP_BR_ANY;
  wire is_data_op  = is_flip_var | is_flip_imm | is_set_var | is_sel_vec | is_sel_imm;
  wire is_branch   = is_br_all | is_br_any;
  wire is_known    = is_data_op | is_branch;

  // Exceptions checked ahead of execution; none depends on data
  wire exc_rsv = op_valid & is_known & ~unit_present;
  wire exc_dis = op_valid & is_known & unit_present & ~unit_enabled;
  wire go      = op_valid & is_known & unit_present & unit_enabled;

  ////////////////////////////////////////////////////////////////////////////
  // Flip/set lanes
  genvar g;
  generate
    for (g = 0; g < NLANE; g++) begin : g_lane
      sbv_lane u_lane (
        .src     (first_source_vector[LANE_W*g +: LANE_W]),
        .sel     (select_vector[LANE_W*g +: LANE_W]),
        .imm_idx (byte_immediate[BIDX_W-1:0]),
        .use_imm (is_flip_imm),
        .do_set  (is_set_var),
        .fmt     (element_format),
        .res     (flip_set_res[LANE_W*g +: LANE_W])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Bitwise select, format ignored
  wire [VEC_W-1:0] imm_rep  = {(VEC_W/IMM_W){byte_immediate}};
  wire [VEC_W-1:0] sel_vec  = (first_source_vector & ~dest_vector)
                            | (select_vector & dest_vector);
  wire [VEC_W-1:0] sel_imm  = (first_source_vector & ~dest_vector)
                            | (imm_rep & dest_vector);
  // Combinational from pre-instruction operands only
  assign nxt_result = is_sel_vec ? sel_vec :
                      is_sel_imm ? sel_imm : flip_set_res;

  ////////////////////////////////////////////////////////////////////////////
  // Branch
  sbv_branch u_branch (
    .vec      (select_vector),
    .fmt      (element_format),
    .any_mode (is_br_any),
    .word_off (branch_word_offset),
    .cond     (br_cond),
    .byte_off (br_byte_off)
  );

  wire take = go & is_branch & br_cond;
  // Target relative to delay-slot address
  wire [GP_W-1:0] br_target = delay_slot_pc + br_byte_off;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      SBV_ST_IDLE:  if (take) nxt_state = SBV_ST_REDIR;
      SBV_ST_REDIR: nxt_state = SBV_ST_IDLE;
      default:      nxt_state = SBV_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_ff        <= SBV_ST_IDLE;
      result_ff       <= '0;
      result_valid_ff <= 1'b0;
      branch_taken_ff <= 1'b0;
      br_target_ff    <= '0;
      exc_reserved_ff <= 1'b0;
      exc_disabled_ff <= 1'b0;
    end else begin
      state_ff        <= nxt_state;
      result_valid_ff <= go & is_data_op;
      if (go & is_data_op) result_ff <= nxt_result;
      branch_taken_ff <= take;
      if (take) br_target_ff <= br_target;
      exc_reserved_ff <= exc_rsv;
      exc_disabled_ff <= exc_dis;
    end
  end

  // PC update two cycles after the branch, letting the delay slot run
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pc_load_ff   <= 1'b0;
      pc_target_ff <= '0;
    end else begin
      pc_load_ff   <= state_ff == SBV_ST_REDIR;
      pc_target_ff <= br_target_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_take;
    op_valid && unit_present && unit_enabled && is_branch && br_cond;
  endsequence
  sequence s_redirect;
    ##1 branch_taken_ff ##1 pc_load_ff;
  endsequence
  sequence s_data_go;
    op_valid && unit_present && unit_enabled && is_data_op;
  endsequence
  sequence s_data_done;
    ##1 (result_valid_ff && !branch_taken_ff && !exc_reserved_ff && !exc_disabled_ff);
  endsequence

  property p_redirect;
    @(posedge clk) disable iff (reset) s_take |-> s_redirect;
  endproperty
  a_redirect: assert property (p_redirect) else $error("taken branch did not load pc");

  property p_target;
    @(posedge clk) disable iff (reset)
      s_take |-> ##2 pc_target_ff == $past(delay_slot_pc, 2)
                   + (GP_W'(signed'($past(branch_word_offset, 2))) << OFF_SH);
  endproperty
  a_target: assert property (p_target) else $error("branch target wrong");

  property p_no_load;
    @(posedge clk) disable iff (reset) pc_load_ff |-> $past(branch_taken_ff);
  endproperty
  a_no_load: assert property (p_no_load) else $error("pc load without branch");

  property p_any;
    @(posedge clk) disable iff (reset)
      (go && is_br_any) |=> branch_taken_ff == (|$past(select_vector));
  endproperty
  a_any: assert property (p_any) else $error("any-bit branch wrong");

  property p_all_d;
    @(posedge clk) disable iff (reset)
      (go && is_br_all && element_format == SBV_FMT_D) |=>
        branch_taken_ff == ((|$past(select_vector[63:0])) && (|$past(select_vector[127:64])));
  endproperty
  a_all_d: assert property (p_all_d) else $error("all-lanes branch wrong");

  property p_sel;
    @(posedge clk) disable iff (reset)
      (go && is_sel_vec) |=> result_ff == (($past(first_source_vector) & ~$past(dest_vector))
                                        | ($past(select_vector) & $past(dest_vector)));
  endproperty
  a_sel: assert property (p_sel) else $error("vector select wrong");

  property p_flip_b;
    @(posedge clk) disable iff (reset)
      (go && is_flip_imm && element_format == SBV_FMT_B) |=>
        result_ff[7:0] == ($past(first_source_vector[7:0]) ^ (8'h01 << $past(byte_immediate[2:0])));
  endproperty
  a_flip_b: assert property (p_flip_b) else $error("immediate flip wrong");

  property p_exc;
    @(posedge clk) disable iff (reset)
      (op_valid && is_known && !unit_present) |=> exc_reserved_ff && !result_valid_ff;
  endproperty
  a_exc: assert property (p_exc) else $error("reserved exception missing");

  property p_data;
    @(posedge clk) disable iff (reset) s_data_go |-> s_data_done;
  endproperty
  a_data: assert property (p_data) else $error("data op raised an exception");

  property p_flip_vb;
    @(posedge clk) disable iff (reset)
      (go && is_flip_var && element_format == SBV_FMT_B) |=>
        result_ff[7:0] == ($past(first_source_vector[7:0])
                           ^ (8'h01 << $past(select_vector[2:0])));
  endproperty
  a_flip_vb: assert property (p_flip_vb) else $error("byte flip wrong");

  property p_flip_vh;
    @(posedge clk) disable iff (reset)
      (go && is_flip_var && element_format == SBV_FMT_H) |=>
        result_ff[127:112] == ($past(first_source_vector[127:112])
                               ^ (16'h0001 << $past(select_vector[115:112])));
  endproperty
  a_flip_vh: assert property (p_flip_vh) else $error("half flip wrong");

  property p_flip_vw;
    @(posedge clk) disable iff (reset)
      (go && is_flip_var && element_format == SBV_FMT_W) |=>
        result_ff[127:96] == ($past(first_source_vector[127:96])
                              ^ (32'h0000_0001 << $past(select_vector[100:96])));
  endproperty
  a_flip_vw: assert property (p_flip_vw) else $error("word flip wrong");

  property p_set_vh;
    @(posedge clk) disable iff (reset)
      (go && is_set_var && element_format == SBV_FMT_H) |=>
        result_ff[15:0] == ($past(first_source_vector[15:0])
                            | (16'h0001 << $past(select_vector[3:0])));
  endproperty
  a_set_vh: assert property (p_set_vh) else $error("half set wrong");

  property p_set_vd;
    @(posedge clk) disable iff (reset)
      (go && is_set_var && element_format == SBV_FMT_D) |=>
        result_ff[63:0] == ($past(first_source_vector[63:0])
                            | (64'h0000_0000_0000_0001 << $past(select_vector[5:0])));
  endproperty
  a_set_vd: assert property (p_set_vd) else $error("double set wrong");

  property p_flip_id;
    @(posedge clk) disable iff (reset)
      (go && is_flip_imm && element_format == SBV_FMT_D) |=>
        result_ff[127:64] == ($past(first_source_vector[127:64])
                              ^ (64'h0000_0000_0000_0001 << $past(byte_immediate[5:0])));
  endproperty
  a_flip_id: assert property (p_flip_id) else $error("double immediate flip wrong");

  property p_sel_imm;
    @(posedge clk) disable iff (reset)
      (go && is_sel_imm) |=>
        result_ff == (($past(first_source_vector) & ~$past(dest_vector))
                      | ({(VEC_W/IMM_W){$past(byte_immediate)}} & $past(dest_vector)));
  endproperty
  a_sel_imm: assert property (p_sel_imm) else $error("immediate select wrong");

  property p_all_b0;
    @(posedge clk) disable iff (reset)
      (go && is_br_all && element_format == SBV_FMT_B && select_vector[7:0] == 8'h00)
        |=> !branch_taken_ff;
  endproperty
  a_all_b0: assert property (p_all_b0) else $error("branch taken on zero byte");

  property p_all_h0;
    @(posedge clk) disable iff (reset)
      (go && is_br_all && element_format == SBV_FMT_H && select_vector[127:112] == 16'h0000)
        |=> !branch_taken_ff;
  endproperty
  a_all_h0: assert property (p_all_h0) else $error("branch taken on zero half");

  property p_all_w;
    @(posedge clk) disable iff (reset)
      (go && is_br_all && element_format == SBV_FMT_W) |=>
        branch_taken_ff == ((|$past(select_vector[31:0])) && (|$past(select_vector[63:32]))
          && (|$past(select_vector[95:64])) && (|$past(select_vector[127:96])));
  endproperty
  a_all_w: assert property (p_all_w) else $error("word all-lanes branch wrong");

  property p_exc_dis;
    @(posedge clk) disable iff (reset)
      (op_valid && is_known && unit_present && !unit_enabled) |=>
        exc_disabled_ff && !exc_reserved_ff && !result_valid_ff && !branch_taken_ff;
  endproperty
  a_exc_dis: assert property (p_exc_dis) else $error("disabled exception missing");

  property p_none;
    @(posedge clk) disable iff (reset)
      (op_valid && op_code == SBV_OP_NONE) |=>
        !result_valid_ff && !branch_taken_ff && !exc_reserved_ff && !exc_disabled_ff;
  endproperty
  a_none: assert property (p_none) else $error("idle code had an effect");
endmodule

// ---- logic/sbv_pkg.sv ----
/*
  Shared constants and types for the SIMD bit-operation and vector-branch unit.
  Assumes a 128-bit vector register and a 64-bit program counter in the host core.
*/
package sbv_pkg;
  localparam int VEC_W   = 128;
  localparam int GP_W    = 64;
  localparam int OFF_W   = 16;
  localparam int IMM_W   = 8;
  localparam int BIDX_W  = 6;
  localparam int LANE_W  = 64;
  localparam int NLANE   = VEC_W / LANE_W;
  // Bit index widths per element format
  localparam int IDX_B   = 3;
  localparam int IDX_H   = 4;
  localparam int IDX_W   = 5;
  localparam int IDX_D   = 6;
  // Word offset to byte offset shift
  localparam int OFF_SH  = 2;

  typedef enum logic [1:0] {
    SBV_FMT_B = 2'h0,
    SBV_FMT_H = 2'h1,
    SBV_FMT_W = 2'h2,
    SBV_FMT_D = 2'h3
  } sbv_fmt_t;

  typedef enum logic [2:0] {
    SBV_OP_FLIP_VAR = 3'h0,
    SBV_OP_FLIP_IMM = 3'h1,
    SBV_OP_SET_VAR  = 3'h2,
    SBV_OP_SEL_VEC  = 3'h3,
    SBV_OP_SEL_IMM  = 3'h4,
    SBV_OP_BR_ALL   = 3'h5,
    SBV_OP_BR_ANY   = 3'h6,
    SBV_OP_NONE     = 3'h7
  } sbv_op_t;

  typedef enum logic [1:0] {
    SBV_ST_IDLE  = 2'h1,
    SBV_ST_REDIR = 2'h2
  } sbv_state_t;
endpackage

// ---- logic/sbv_lane.sv ----
/*
  One 64-bit lane of the bit flip/set datapath, split per element format.
  Assumes operands are stable in the cycle the top samples the result.
*/
`timescale 1ns/1ps
module sbv_lane
  import sbv_pkg::*;
(
  input  wire logic [LANE_W-1:0] src,
  input  wire logic [LANE_W-1:0] sel,
  input  wire logic [BIDX_W-1:0] imm_idx,
  input  wire logic              use_imm,
  input  wire logic              do_set,
  input  wire logic [1:0]        fmt,
  output logic      [LANE_W-1:0] res
);
  logic [LANE_W-1:0] mask_b;
  logic [LANE_W-1:0] mask_h;
  logic [LANE_W-1:0] mask_w;
  logic [LANE_W-1:0] mask_d;
  logic [LANE_W-1:0] mask;

  ////////////////////////////////////////////////////////////////////////////
  // One-hot masks per element; only low index bits are used
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_b
      wire [IDX_B-1:0] ib = use_imm ? imm_idx[IDX_B-1:0] : sel[8*g +: IDX_B];
      assign mask_b[8*g +: 8] = 8'h01 << ib;
    end
    for (g = 0; g < 4; g++) begin : g_h
      wire [IDX_H-1:0] ih = use_imm ? imm_idx[IDX_H-1:0] : sel[16*g +: IDX_H];
      assign mask_h[16*g +: 16] = 16'h0001 << ih;
    end
    for (g = 0; g < 2; g++) begin : g_w
      wire [IDX_W-1:0] iw = use_imm ? imm_idx[IDX_W-1:0] : sel[32*g +: IDX_W];
      assign mask_w[32*g +: 32] = 32'h0000_0001 << iw;
    end
  endgenerate
  wire [IDX_D-1:0] id_sel = use_imm ? imm_idx : sel[IDX_D-1:0];
  assign mask_d = 64'h0000_0000_0000_0001 << id_sel;

  assign mask = (fmt == SBV_FMT_B) ? mask_b :
                (fmt == SBV_FMT_H) ? mask_h :
                (fmt == SBV_FMT_W) ? mask_w : mask_d;

  assign res = do_set ? (src | mask) : (src ^ mask);
endmodule

// ---- logic/sbv_branch.sv ----
/*
  Branch condition and byte offset for the vector branches.
  Assumes the tested vector is the current register value.
*/
`timescale 1ns/1ps
module sbv_branch
  import sbv_pkg::*;
(
  input  wire logic [VEC_W-1:0] vec,
  input  wire logic [1:0]       fmt,
  input  wire logic             any_mode,
  input  wire logic [OFF_W-1:0] word_off,
  output logic                  cond,
  output logic      [GP_W-1:0]  byte_off
);
  logic [15:0] nz_b;
  logic [7:0]  nz_h;
  logic [3:0]  nz_w;
  logic [1:0]  nz_d;
  logic        all_nz;

  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_b
      assign nz_b[g] = |vec[8*g +: 8];
    end
    for (g = 0; g < 8; g++) begin : g_h
      assign nz_h[g] = |vec[16*g +: 16];
    end
    for (g = 0; g < 4; g++) begin : g_w
      assign nz_w[g] = |vec[32*g +: 32];
    end
    for (g = 0; g < 2; g++) begin : g_d
      assign nz_d[g] = |vec[64*g +: 64];
    end
  endgenerate

  assign all_nz = (fmt == SBV_FMT_B) ? &nz_b :
                  (fmt == SBV_FMT_H) ? &nz_h :
                  (fmt == SBV_FMT_W) ? &nz_w : &nz_d;
  assign cond = any_mode ? (|vec) : all_nz;
  // Sign-extended word offset scaled to bytes
  assign byte_off = {{(GP_W-OFF_W-OFF_SH){word_off[OFF_W-1]}}, word_off, 2'h0};
endmodule

// ---- tb/sbv_vreg_model.sv ----
/*
  Behavioural vector register file standing in for the host pipeline.
  Assumes loads arrive only while no op is issued and one write per result pulse.
*/
`timescale 1ns/1ps
module sbv_vreg_model
  import sbv_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             ld_en,
  input  wire logic [1:0]       ld_idx,
  input  wire logic [VEC_W-1:0] ld_data,
  input  wire logic             issue,
  input  wire logic [1:0]       rs_idx,
  input  wire logic [1:0]       rt_idx,
  input  wire logic [1:0]       rd_idx,
  input  wire logic             wr_en,
  input  wire logic [VEC_W-1:0] wr_data,
  output logic      [VEC_W-1:0] rs_vec,
  output logic      [VEC_W-1:0] rt_vec,
  output logic      [VEC_W-1:0] rd_vec
);
  logic [VEC_W-1:0] regs_ff [4];
  logic [1:0]       pend_ff;

  // Forward a pending writeback so back-to-back ops see it
  assign rs_vec = (wr_en && pend_ff == rs_idx) ? wr_data : regs_ff[rs_idx];
  assign rt_vec = (wr_en && pend_ff == rt_idx) ? wr_data : regs_ff[rt_idx];
  assign rd_vec = (wr_en && pend_ff == rd_idx) ? wr_data : regs_ff[rd_idx];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      regs_ff <= '{default: '0};
      pend_ff <= 2'h0;
    end else begin
      if (issue) pend_ff <= rd_idx;
      if (wr_en) regs_ff[pend_ff] <= wr_data;
      if (ld_en) regs_ff[ld_idx] <= ld_data;
    end
  end
endmodule

// ---- tb/simd_bit_ops_and_vector_branch_tb.sv ----
/*
  Self-checking bench for the bit-op and vector-branch unit with a register file model.
  Assumes the package constants and the one-op-per-cycle issue contract.
*/
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_fail++; $display("wrong value at %0t: output differs", $time); end end
module simd_bit_ops_and_vector_branch_tb
  import sbv_pkg::*;
;
  logic             clk = 1'b0, reset = 1'b1, op_valid = 1'b0, ld_en = 1'b0;
  logic             unit_present = 1'b1, unit_enabled = 1'b1, bt_seen = 1'b0;
  logic [2:0]       op_code = 3'h7;
  logic [1:0]       element_format = 2'h0, rs_idx = 2'h0, rt_idx = 2'h0, rd_idx = 2'h0;
  logic [1:0]       ld_idx = 2'h0;
  logic [IMM_W-1:0] byte_immediate = 8'h00;
  logic [OFF_W-1:0] branch_word_offset = 16'h0000;
  logic [GP_W-1:0]  delay_slot_pc = 64'h0, pc_target_ff;
  logic [VEC_W-1:0] ld_data = '0, first_source_vector, select_vector, dest_vector, result_ff, v;
  logic             result_valid_ff, branch_taken_ff, pc_load_ff, exc_reserved_ff, exc_disabled_ff;
  logic [VEC_W-1:0] sh [4] = '{default: '0};
  logic [VEC_W+1:0] q_res [$];
  logic [GP_W-1:0]  q_br [$];
  int               n_fail = 0, check_count = 0, t;
  // No branch directly follows another branch
  logic [2:0]       seq [7] = '{3'h5, 3'h0, 3'h6, 3'h1, 3'h2, 3'h3, 3'h4};

  always #12.5 clk = ~clk;

  sbv_unit sbv_unit_inst (.clk(clk), .reset(reset), .op_valid(op_valid), .op_code(op_code),
    .element_format(element_format), .first_source_vector(first_source_vector),
    .select_vector(select_vector), .dest_vector(dest_vector), .byte_immediate(byte_immediate),
    .branch_word_offset(branch_word_offset), .delay_slot_pc(delay_slot_pc),
    .unit_present(unit_present), .unit_enabled(unit_enabled), .result_ff(result_ff),
    .result_valid_ff(result_valid_ff), .branch_taken_ff(branch_taken_ff),
    .pc_load_ff(pc_load_ff), .pc_target_ff(pc_target_ff), .exc_reserved_ff(exc_reserved_ff),
    .exc_disabled_ff(exc_disabled_ff));

  sbv_vreg_model sbv_vreg_model_inst (.clk(clk), .reset(reset), .ld_en(ld_en), .ld_idx(ld_idx),
    .ld_data(ld_data), .issue(op_valid && op_code < 3'h5), .rs_idx(rs_idx), .rt_idx(rt_idx),
    .rd_idx(rd_idx), .wr_en(result_valid_ff), .wr_data(result_ff),
    .rs_vec(first_source_vector), .rt_vec(select_vector), .rd_vec(dest_vector));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [VEC_W-1:0] ref_vec(input logic [2:0] op, input logic [1:0] fmt,
      input logic [VEC_W-1:0] s, input logic [VEC_W-1:0] tv, input logic [VEC_W-1:0] d,
      input logic [7:0] im);
    int               w;
    int               b;
    logic [VEC_W-1:0] r;
    w = 8 << fmt;
    r = s;
    if (op == 3'h3) return (s & ~d) | (tv & d);
    if (op == 3'h4) return (s & ~d) | ({16{im}} & d);
    for (int i = 0; i < VEC_W / w; i++) begin
      b = i * w + ((op == 3'h1 ? int'(im) : int'(tv[i * w +: 6])) & (w - 1));
      r[b] = (op == 3'h2) ? 1'b1 : ~s[b];
    end
    return r;
  endfunction

  function automatic logic all_nz(input logic [1:0] fmt, input logic [VEC_W-1:0] tv);
    int               w;
    logic             c;
    logic [VEC_W-1:0] m;
    w = 8 << fmt;
    c = 1'b1;
    m = (VEC_W'(1) << w) - VEC_W'(1);
    for (int i = 0; i < VEC_W / w; i++) if (((tv >> (i * w)) & m) == '0) c = 1'b0;
    return c;
  endfunction

  function automatic logic [VEC_W+1:0] popr();
    return q_res.size() > 0 ? q_res.pop_front() : 'x;
  endfunction

  function automatic logic [GP_W-1:0] popb();
    return q_br.size() > 0 ? q_br.pop_front() : 'x;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  task automatic ld(input int i, input logic [VEC_W-1:0] d);
    @(negedge clk);
    op_valid = 1'b0;
    ld_en = 1'b1;
    ld_idx = 2'(i);
    ld_data = d;
    sh[i] = d;
    @(negedge clk);
    ld_en = 1'b0;
  endtask

  task automatic issue(input logic [2:0] op, input int s, input int tt, input int d);
    logic [VEC_W-1:0] e;
    @(negedge clk);
    op_valid = 1'b1;
    op_code = op;
    element_format = 2'($urandom);
    byte_immediate = 8'($urandom);
    branch_word_offset = 16'($urandom);
    delay_slot_pc = {$urandom, $urandom};
    rs_idx = 2'(s);
    rt_idx = 2'(tt);
    rd_idx = 2'(d);
    if (op == 3'h7) e = '0;
    else if (!unit_present) q_res.push_back({2'h1, VEC_W'(0)});
    else if (!unit_enabled) q_res.push_back({2'h2, VEC_W'(0)});
    else if (op < 3'h5) begin
      e = ref_vec(op, element_format, sh[s], sh[tt], sh[d], byte_immediate);
      q_res.push_back({2'h0, e});
      sh[d] = e;
    end else if (op == 3'h6 ? sh[tt] != '0 : all_nz(element_format, sh[tt]))
      q_br.push_back(delay_slot_pc + {{(GP_W-OFF_W-OFF_SH){branch_word_offset[15]}},
                                     branch_word_offset, 2'b00});
  endtask

  task automatic idle();
    @(negedge clk);
    op_valid = 1'b0;
    op_code = 3'h7;
  endtask

  task give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(negedge clk) begin
    if (!reset) begin
      if (result_valid_ff) `CHK({2'h0, result_ff}, popr())
      if (exc_reserved_ff) `CHK({2'h1, VEC_W'(0)}, popr())
      if (exc_disabled_ff) `CHK({2'h2, VEC_W'(0)}, popr())
      if (pc_load_ff) `CHK({bt_seen, pc_target_ff}, {1'b1, popb()})
      bt_seen = branch_taken_ff;
    end
  end

  initial begin
    void'($urandom(32'he029f92b));
    repeat (6) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    `CHK({result_valid_ff, branch_taken_ff, pc_load_ff, exc_reserved_ff, exc_disabled_ff}, 5'h0)
    $display("test reset done");
    for (int k = 0; k < 84; k++) begin
      if (k % 7 == 0) for (int i = 0; i < 4; i++) ld(i, {$urandom, $urandom, $urandom, $urandom});
      t = $urandom_range(3, 0);
      if (seq[k % 7] >= 3'h5) begin
        v = {$urandom, $urandom, $urandom, $urandom};
        if (k % 3 == 0) v = '0;
        else if (k % 3 == 1) v[7:0] = 8'h00;
        ld(t, v);
      end
      issue(seq[k % 7], $urandom_range(3, 0), t, $urandom_range(3, 0));
    end
    idle();
    $display("test data and branch ops done");
    unit_present = 1'b0;
    issue(3'h0, 0, 1, 2);
    issue(3'h5, 0, 1, 2);
    idle();
    unit_present = 1'b1;
    unit_enabled = 1'b0;
    issue(3'h3, 1, 2, 3);
    issue(3'h6, 1, 2, 3);
    idle();
    unit_enabled = 1'b1;
    issue(3'h7, 0, 1, 2);
    issue(3'h2, 0, 1, 0);
    idle();
    repeat (4) @(negedge clk);
    `CHK(q_res.size() + q_br.size(), 0)
    $display("test exceptions and idle code done");
    give_verdict();
  end

  initial begin
    #(25 * 3000);
    n_fail++;
    $display("wrong value at %0t: run did not finish", $time);
    give_verdict();
  end
endmodule
